// ===== core/bbl_regs.svh
`ifndef BBL_REGS_SVH
`define BBL_REGS_SVH
// register indices; the byte address on the bus is four times the index
`define BBL_IDX_L1_THR 8'h2c
`define BBL_IDX_L1_HOLD 8'h2d
`define BBL_IDX_L0_DWELL 8'h2e
`define BBL_IDX_L0_ATK 8'h2f
`define BBL_IDX_L0_RLS 8'h30
`define BBL_IDX_L0_THR 8'h31
`define BBL_IDX_CTRL 8'h38
`define BBL_IDX_STAT 8'h39
// reset values
`define BBL_RST_L1_THR 8'h40
`define BBL_RST_L1_HOLD 8'h20
`define BBL_RST_L0_DWELL 8'h02
`define BBL_RST_L0_ATK 8'h06
`define BBL_RST_L0_RLS 8'h3e
`define BBL_RST_L0_THR 8'h37
// writable bits, reserved bits read zero
`define BBL_MASK_L1_HOLD 8'hf0
`define BBL_MASK_STEP_REG 8'hfe
`define BBL_MASK_FULL 8'hff
// field positions
`define BBL_RATE_LSB 5
`define BBL_STEP_LSB 1
`define BBL_DIS1_BIT 4
`define BBL_SRC_BIT 0
`define BBL_HLDCLR_BIT 1
// threshold decode, millivolts
`define BBL_BAT_BASE_MV 16'h0a8c
`define BBL_HV_BASE_MV 16'h157c
`define BBL_THR_STEP_MV 16'h0032
`define BBL_BAT_MAX_CODE 8'h38
// gain steps in units of 0.0001 dB
`define BBL_STEP_FINE 19'h0_0271
`define BBL_STEP_BASE 19'h0_1388
`define BBL_STEP_INC 19'h0_0f76
`define BBL_STEP_TOP 19'h0_ea60
`define BBL_DB_UNIT 19'h0_2710
// timing
`define BBL_CLK_PERIOD_NS 25
`define BBL_TICK_NS 2500
`define BBL_TICK_CYC (`BBL_TICK_NS / `BBL_CLK_PERIOD_NS)
`define BBL_MS_NS 1000000
`define BBL_MS_TICKS (`BBL_MS_NS / `BBL_TICK_NS)
`define BBL_HOLD_INF 3'h7
`endif

// ===== core/bbl_pkg.sv
`default_nettype none
package bbl_pkg;
  // limiter sequence, gray coded along idle-dwell-attack-hold-release
  typedef enum logic [2:0]
  {
    st_idle = 3'h0,
    st_dwell = 3'h1,
    st_attack = 3'h3,
    st_hold = 3'h2,
    st_release = 3'h6
  } bbl_state_e;

  typedef logic [18:0] bbl_atten_t;

  typedef struct packed
  {
    logic [7:0] thr1;
    logic [2:0] hold1;
    logic dis1;
    logic [2:0] dwell0;
    logic [3:0] atk_step0;
    logic [2:0] atk_rate0;
    logic [3:0] rls_step0;
    logic [2:0] rls_rate0;
    logic [4:0] max_att0;
    logic [7:0] thr0;
    logic src;
  } bbl_cfg_s;
endpackage : bbl_pkg
`default_nettype wire

// ===== core/bbl_tick_div.sv
`default_nettype none
`include "bbl_regs.svh"
module bbl_tick_div #(
  parameter int TICK_CYC = `BBL_TICK_CYC,
  parameter int MS_TICKS = `BBL_MS_TICKS
) (
  input wire logic mclk,
  input wire logic reset,
  output logic tick_fine,
  output logic tick_ms
);
  logic [11:0] pre;
  logic [11:0] next_pre;
  logic [11:0] ms_cnt;
  logic [11:0] next_ms_cnt;
  logic next_tick_fine;
  logic next_tick_ms;

  // two cascaded dividers keep each counter small
  always_comb
  begin
    next_pre = pre + 12'h001;
    next_ms_cnt = ms_cnt;
    next_tick_fine = 1'b0;
    next_tick_ms = 1'b0;
    if (pre == 12'(TICK_CYC - 1))
    begin
      next_pre = 12'h000;
      next_tick_fine = 1'b1;
      next_ms_cnt = ms_cnt + 12'h001;
      if (ms_cnt == 12'(MS_TICKS - 1))
      begin
        next_ms_cnt = 12'h000;
        next_tick_ms = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pre <= 12'h000;
      ms_cnt <= 12'h000;
      tick_fine <= 1'b0;
      tick_ms <= 1'b0;
    end
    else
    begin
      pre <= next_pre;
      ms_cnt <= next_ms_cnt;
      tick_fine <= next_tick_fine;
      tick_ms <= next_tick_ms;
    end
  end
endmodule : bbl_tick_div
`default_nettype wire

// ===== core/bbl_interval_timer.sv
`default_nettype none
module bbl_interval_timer #(
  parameter int W = 12
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic tick,
  input wire logic [W-1:0] count,
  output logic done
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic armed;
  logic next_armed;

  // a zero count finishes one cycle after the load
  always_comb
  begin
    next_cnt = cnt;
    next_armed = armed;
    if (start)
    begin
      next_cnt = count;
      next_armed = 1'b1;
    end
    else if (armed && tick && cnt != '0)
      next_cnt = cnt - W'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cnt <= '0;
      armed <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      armed <= next_armed;
    end
  end

  // done reads registered state only, so a caller may restart from it without a loop
  assign done = armed && cnt == '0;
endmodule : bbl_interval_timer
`default_nettype wire

// ===== core/bbl_limiter.sv
// Chosen here: the APB interface to the registers.
`default_nettype none
`include "bbl_regs.svh"
module bbl_limiter #(
  parameter int AW = 10
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] battery_supply_mv,
  input wire logic [15:0] high_voltage_supply_mv,
  output logic [18:0] gain_reduction,
  output logic limiting_active
);
  localparam int NREG = 6;
  localparam logic [7:0] RST_V [NREG] = '{`BBL_RST_L1_THR, `BBL_RST_L1_HOLD, `BBL_RST_L0_DWELL,
    `BBL_RST_L0_ATK, `BBL_RST_L0_RLS, `BBL_RST_L0_THR};
  localparam logic [7:0] MASK_V [NREG] = '{`BBL_MASK_FULL, `BBL_MASK_L1_HOLD, `BBL_MASK_STEP_REG,
    `BBL_MASK_STEP_REG, `BBL_MASK_FULL, `BBL_MASK_FULL};

  logic [7:0] cfg_q [NREG];
  logic [7:0] next_cfg_q [NREG];
  logic src;
  logic next_src;
  logic hold_clear;
  logic next_hold_clear;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [7:0] idx;
  logic wr_en;
  logic access;
  bbl_pkg::bbl_cfg_s cfg;
  bbl_pkg::bbl_state_e state;
  bbl_pkg::bbl_state_e next_state;
  bbl_pkg::bbl_atten_t atten;
  bbl_pkg::bbl_atten_t next_atten;
  bbl_pkg::bbl_atten_t max_lim;
  bbl_pkg::bbl_atten_t atk_amt;
  bbl_pkg::bbl_atten_t rls_amt;
  logic next_limiting;
  logic below;
  logic next_below;
  logic [15:0] sup_mv;
  logic [15:0] thr1_mv;
  logic [15:0] thr0_mv;
  logic tick_fine;
  logic tick_ms;
  logic tmr_start;
  logic tmr_tick;
  logic tmr_done;
  logic [11:0] tmr_count;

  // threshold code to millivolts for the monitored supply
  function automatic logic [15:0] thr_mv(input logic [7:0] code, input logic hv);
    logic [7:0] c;
    c = code;
    if (!hv && code > `BBL_BAT_MAX_CODE)
      c = `BBL_BAT_MAX_CODE; // reserved codes act as the top one
    if (hv)
      thr_mv = `BBL_HV_BASE_MV + 16'(`BBL_THR_STEP_MV * 16'(c));
    else
      thr_mv = `BBL_BAT_BASE_MV + 16'(`BBL_THR_STEP_MV * 16'(c));
  endfunction : thr_mv

  // gain step: fine first code, then a constant increment, capped at 6 dB
  function automatic bbl_pkg::bbl_atten_t step_amt(input logic [3:0] c);
    if (c == 4'h0)
      step_amt = `BBL_STEP_FINE;
    else if (c == 4'hf)
      step_amt = `BBL_STEP_TOP;
    else
      step_amt = `BBL_STEP_BASE + 19'(`BBL_STEP_INC * 19'(c - 4'h1));
  endfunction : step_amt

  // interval for the state about to run; dwell/attack in 2.5 us ticks, hold/release in ms
  function automatic logic [11:0] interval(input bbl_pkg::bbl_state_e s, input bbl_pkg::bbl_cfg_s k);
    interval = 12'h000;
    case (s)
      bbl_pkg::st_dwell:
      begin
        case (k.dwell0)
          3'h0: interval = 12'h000;
          3'h1: interval = 12'h028;
          3'h2: interval = 12'h064;
          3'h3: interval = 12'h0c8;
          3'h4: interval = 12'h190;
          3'h5: interval = 12'h320;
          3'h6: interval = 12'h640;
          default: interval = 12'hc80;
        endcase
      end
      bbl_pkg::st_attack:
      begin
        case (k.atk_rate0)
          3'h0: interval = 12'h001;
          3'h1: interval = 12'h002;
          3'h2: interval = 12'h004;
          3'h3: interval = 12'h00a;
          3'h4: interval = 12'h014;
          3'h5: interval = 12'h028;
          3'h6: interval = 12'h064;
          default: interval = 12'h0c8;
        endcase
      end
      bbl_pkg::st_hold:
      begin
        case (k.hold1)
          3'h0: interval = 12'h000;
          3'h1: interval = 12'h00a;
          3'h2: interval = 12'h064;
          3'h3: interval = 12'h0fa;
          3'h4: interval = 12'h1f4;
          3'h5: interval = 12'h3e8;
          default: interval = 12'h7d0;
        endcase
      end
      default:
      begin
        case (k.rls_rate0)
          3'h0: interval = 12'h005;
          3'h1: interval = 12'h00a;
          3'h2: interval = 12'h019;
          3'h3: interval = 12'h032;
          3'h4: interval = 12'h064;
          3'h5: interval = 12'h0fa;
          3'h6: interval = 12'h1f4;
          default: interval = 12'h3e8;
        endcase
      end
    endcase
  endfunction : interval

  // bus decode; a write lands only at the edge that completes the access
  assign idx = paddr[AW-1:2];
  assign access = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite;

  // field view of the stored bytes
  always_comb
  begin
    cfg.thr1 = cfg_q[0];
    cfg.hold1 = cfg_q[1][`BBL_RATE_LSB +: 3];
    cfg.dis1 = cfg_q[1][`BBL_DIS1_BIT];
    cfg.dwell0 = cfg_q[2][`BBL_RATE_LSB +: 3];
    cfg.atk_step0 = cfg_q[2][`BBL_STEP_LSB +: 4];
    cfg.atk_rate0 = cfg_q[3][`BBL_RATE_LSB +: 3];
    cfg.rls_step0 = cfg_q[3][`BBL_STEP_LSB +: 4];
    cfg.rls_rate0 = cfg_q[4][`BBL_RATE_LSB +: 3];
    cfg.max_att0 = cfg_q[4][4:0];
    cfg.thr0 = cfg_q[5];
    cfg.src = src;
  end

  // register writes; reserved bits stay zero, hold clear is a one-cycle pulse
  always_comb
  begin
    for (int i = 0; i < NREG; i++)
    begin
      next_cfg_q[i] = cfg_q[i];
      if (wr_en && paddr[1:0] == 2'h0 && idx == 8'(`BBL_IDX_L1_THR + i))
        next_cfg_q[i] = pwdata[7:0] & MASK_V[i];
    end
    next_src = src;
    next_hold_clear = 1'b0;
    if (wr_en && paddr[1:0] == 2'h0 && idx == `BBL_IDX_CTRL)
    begin
      next_src = pwdata[`BBL_SRC_BIT];
      next_hold_clear = pwdata[`BBL_HLDCLR_BIT];
    end
  end

  // read data and the answer, one wait cycle per access
  always_comb
  begin
    next_pready = access;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (!access)
      next_prdata = 32'h0000_0000;
    else if (paddr[1:0] != 2'h0)
      next_pslverr = 1'b1;
    else if (idx >= `BBL_IDX_L1_THR && idx <= `BBL_IDX_L0_THR)
      next_prdata = {24'h00_0000, cfg_q[3'(idx - `BBL_IDX_L1_THR)]};
    else if (idx == `BBL_IDX_CTRL)
      next_prdata = {31'h0000_0000, src};
    else if (idx == `BBL_IDX_STAT)
      next_prdata = {9'h000, state, below, atten};
    else
      next_pslverr = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NREG; i++)
        cfg_q[i] <= RST_V[i];
      src <= 1'b0;
      hold_clear <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      cfg_q <= next_cfg_q;
      src <= next_src;
      hold_clear <= next_hold_clear;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // supply comparison; level 1 only counts while enabled
  assign sup_mv = src ? high_voltage_supply_mv : battery_supply_mv;
  assign thr1_mv = thr_mv(cfg.thr1, src);
  assign thr0_mv = thr_mv(cfg.thr0, src);
  assign next_below = (sup_mv < thr0_mv) || (!cfg.dis1 && sup_mv < thr1_mv);
  assign max_lim = 19'(`BBL_DB_UNIT * 19'(cfg.max_att0));
  assign atk_amt = step_amt(cfg.atk_step0);
  assign rls_amt = step_amt(cfg.rls_step0);

  bbl_tick_div i_bbl_tick_div (
    .mclk(mclk),
    .reset(reset),
    .tick_fine(tick_fine),
    .tick_ms(tick_ms)
  );

  // one shared timer: its unit follows the running state
  assign tmr_tick = (state == bbl_pkg::st_hold || state == bbl_pkg::st_release) ? tick_ms : tick_fine;
  assign tmr_count = interval(next_state, cfg);

  bbl_interval_timer #(.W(12)) i_bbl_interval_timer (
    .mclk(mclk),
    .reset(reset),
    .start(tmr_start),
    .tick(tmr_tick),
    .count(tmr_count),
    .done(tmr_done)
  );

  // limiter sequence; the timer restarts on every state change and every step
  always_comb
  begin
    next_state = state;
    next_atten = atten;
    tmr_start = 1'b0;
    case (state)
      bbl_pkg::st_idle:
        if (below)
          next_state = bbl_pkg::st_dwell;
      bbl_pkg::st_dwell:
        if (!below)
          next_state = bbl_pkg::st_idle;
        else if (tmr_done)
          next_state = bbl_pkg::st_attack;
      bbl_pkg::st_attack:
        if (!below)
          next_state = bbl_pkg::st_hold;
        else if (tmr_done)
        begin
          tmr_start = 1'b1;
          next_atten = atten + atk_amt;
        end
      bbl_pkg::st_hold:
        if (below)
          next_state = bbl_pkg::st_attack;
        else if (cfg.hold1 == `BBL_HOLD_INF)
        begin
          if (hold_clear)
            next_state = bbl_pkg::st_release;
        end
        else if (tmr_done)
          next_state = bbl_pkg::st_release;
      bbl_pkg::st_release:
        if (below)
          next_state = bbl_pkg::st_attack;
        else if (tmr_done)
        begin
          tmr_start = 1'b1;
          next_atten = (atten > rls_amt) ? atten - rls_amt : 19'h0_0000;
          if (atten <= rls_amt)
            next_state = bbl_pkg::st_idle;
        end
      default:
        next_state = bbl_pkg::st_idle;
    endcase
    // clamp every cycle, so lowering the limit takes hold at once
    if (next_atten > max_lim)
      next_atten = max_lim;
    if (next_state != state)
      tmr_start = 1'b1;
    next_limiting = next_state != bbl_pkg::st_idle;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= bbl_pkg::st_idle;
      atten <= 19'h0_0000;
      below <= 1'b0;
      gain_reduction <= 19'h0_0000;
      limiting_active <= 1'b0;
    end
    else
    begin
      state <= next_state;
      atten <= next_atten;
      below <= next_below;
      gain_reduction <= next_atten;
      limiting_active <= next_limiting;
    end
  end

  thr_top_hv_a: assert property (@(posedge mclk) disable iff (reset)
    src && cfg.thr1 == 8'hff |-> thr1_mv == 16'h474a)
    else $error("level 1 top code not 18.25 V");
  thr_bat_cap_a: assert property (@(posedge mclk) disable iff (reset)
    !src && cfg.thr0 >= 8'h38 |-> thr0_mv == 16'h157c)
    else $error("level 0 battery code not capped at 5.5 V");
  hold_inf_a: assert property (@(posedge mclk) disable iff (reset)
    state == bbl_pkg::st_hold && cfg.hold1 == 3'h7 && !hold_clear && !below |=> state == bbl_pkg::st_hold)
    else $error("infinite hold left without hold clear");
  lvl1_off_a: assert property (@(posedge mclk) disable iff (reset)
    cfg.dis1 && sup_mv >= thr0_mv |=> !below)
    else $error("disabled level 1 still triggers");
  dwell_zero_a: assert property (@(posedge mclk) disable iff (reset)
    state == bbl_pkg::st_dwell && cfg.dwell0 == 3'h0 && below |=> state == bbl_pkg::st_attack)
    else $error("zero dwell did not attack at once");
  attack_step_a: assert property (@(posedge mclk) disable iff (reset)
    state == bbl_pkg::st_attack && below && tmr_done |=> atten > $past(atten) || atten == $past(max_lim))
    else $error("attack step did not lower gain");
  release_step_a: assert property (@(posedge mclk) disable iff (reset)
    state == bbl_pkg::st_release && !below && tmr_done |=> atten < $past(atten) || atten == 19'h0_0000)
    else $error("release step did not restore gain");
  max_atten_a: assert property (@(posedge mclk) disable iff (reset)
    !$past(reset) |-> atten <= $past(max_lim))
    else $error("attenuation beyond limit");
  idle_zero_a: assert property (@(posedge mclk) disable iff (reset)
    state == bbl_pkg::st_idle |-> atten == 19'h0_0000 && gain_reduction == 19'h0_0000)
    else $error("idle with gain reduced");
  apb_answer_a: assert property (@(posedge mclk) disable iff (reset)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer not one cycle after access");
endmodule : bbl_limiter
`default_nettype wire

// ===== bench/bbl_limiter_tb.sv
`default_nettype none
`include "bbl_regs.svh"
module bbl_limiter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] bat_mv = 16'hffff;
  logic [15:0] hv_mv = 16'hffff;
  logic [18:0] gain_reduction;
  logic limiting_active;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  int gap;
  logic [31:0] rd;
  logic err;
  logic [2:0] rt;
  logic [7:0] ridx [6] = '{`BBL_IDX_L1_THR, `BBL_IDX_L1_HOLD, `BBL_IDX_L0_DWELL, `BBL_IDX_L0_ATK,
    `BBL_IDX_L0_RLS, `BBL_IDX_L0_THR};
  logic [7:0] rrst [6] = '{8'h40, 8'h20, 8'h02, 8'h06, 8'h3e, 8'h37};
  logic [7:0] rmsk [6] = '{8'hff, 8'hf0, 8'hfe, 8'hfe, 8'hff, 8'hff};
  // probe table: supply select, level 0 code, level 1 hold/disable, supply in mv, expect limiting
  logic psrc [9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0] pthr [9] = '{8'h10, 8'h10, 8'hff, 8'hff, 8'h10, 8'hff, 8'hff, 8'h00, 8'h00};
  logic [7:0] phld [9] = '{8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h10, 8'h00};
  logic [15:0] pmv [9] = '{16'h0d7a, 16'h0dde, 16'h154a, 16'h15ae, 16'h186a, 16'h4718, 16'h477c,
    16'h109a, 16'h109a};
  logic pexp [9] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

  bbl_limiter #(.AW(10)) i_bbl_limiter (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .battery_supply_mv(bat_mv), .high_voltage_supply_mv(hv_mv), .gain_reduction(gain_reduction),
    .limiting_active(limiting_active));

  // 25 ns clock
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  // hang guard; the whole run needs about 88k cycles
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 98000)
    begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; the request is held until pready is sampled high
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // the slave answers in the second access-phase cycle
    chk("answer cycles", 32'h0000_0002, k);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, {idx, 2'b00}, d);
  endtask : wr

  task automatic rdreg(input logic [7:0] idx);
    apb(1'b0, {idx, 2'b00}, 32'h0000_0000);
  endtask : rdreg

  task automatic do_reset();
    @(posedge mclk);
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
  endtask : do_reset

  // counts edges until the attenuation output moves; capped so a stuck output cannot hang
  task automatic wait_change(output int c);
    logic [18:0] g;
    g = gain_reduction;
    c = 0;
    while (gain_reduction === g && c < 25000)
    begin
      @(posedge mclk);
      c++;
    end
  endtask : wait_change

  // step size in 0.0001 db: fine code, then 0.5 db rising by 0.3958 db, top code 6 db
  function automatic logic [18:0] step_amt(input logic [3:0] c);
    if (c == 4'h0)
      return 19'h0_0271;
    if (c == 4'hf)
      return 19'h0_ea60;
    return 19'h0_1388 + 19'h0_0f76 * (c - 4'h1);
  endfunction : step_amt

  // attack spacing in clock cycles, 100 cycles per 2.5 us
  function automatic int rate_cyc(input logic [2:0] c);
    int t [8] = '{1, 2, 4, 10, 20, 40, 100, 200};
    return t[c] * 100;
  endfunction : rate_cyc

  initial
  begin
    void'($urandom(32'h5c237a58));
    do_reset();
    for (int i = 0; i < 6; i++)
    begin
      rdreg(ridx[i]);
      chk("reset value", {24'h0, rrst[i]}, rd);
    end
    // random data; reserved bits must read back zero
    for (int i = 0; i < 12; i++)
    begin
      n = $urandom;
      wr(ridx[i % 6], n);
      rdreg(ridx[i % 6]);
      chk("readback", {24'h0, n[7:0] & rmsk[i % 6]}, rd);
    end
    apb(1'b0, 10'h3c0, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    apb(1'b1, 10'h0b1, 32'hffff_ffff);
    chk("misaligned err", 32'h0000_0001, {31'h0, err});
    wr(`BBL_IDX_STAT, 32'hffff_ffff);
    rdreg(`BBL_IDX_STAT);
    chk("status idle", 32'h0000_0000, rd);
    wr(`BBL_IDX_CTRL, 32'h0000_0003);
    rdreg(`BBL_IDX_CTRL);
    chk("ctrl", 32'h0000_0001, rd);
    // threshold decode; a long dwell keeps the limiter from stepping
    wr(`BBL_IDX_L0_DWELL, 32'h0000_00e0);
    wr(`BBL_IDX_L1_THR, 32'h0000_00ff);
    for (int i = 0; i < 9; i++)
    begin
      wr(`BBL_IDX_CTRL, {31'h0, psrc[i]});
      wr(`BBL_IDX_L0_THR, {24'h0, pthr[i]});
      wr(`BBL_IDX_L1_HOLD, {24'h0, phld[i]});
      @(posedge mclk);
      bat_mv <= psrc[i] ? 16'($urandom) : pmv[i];
      hv_mv <= psrc[i] ? pmv[i] : 16'($urandom);
      repeat (4) @(posedge mclk);
      chk("limiting", {31'h0, pexp[i]}, {31'h0, limiting_active});
      bat_mv <= 16'hffff;
      hv_mv <= 16'hffff;
      repeat (4) @(posedge mclk);
    end
    // dwell, cap, infinite hold and hold clear
    do_reset();
    wr(`BBL_IDX_L1_HOLD, 32'h0000_00f0);
    wr(`BBL_IDX_L0_DWELL, 32'h0000_003e);
    wr(`BBL_IDX_L0_ATK, 32'h0000_0000);
    wr(`BBL_IDX_L0_RLS, 32'h0000_0001);
    wr(`BBL_IDX_L0_THR, 32'h0000_0010);
    @(posedge mclk);
    bat_mv <= 16'h0bb8;
    wait_change(n);
    chk("dwell", 32'h0000_0001, {31'h0, n >= 3850 && n <= 4250});
    chk("cap", 32'h0000_2710, {13'h0, gain_reduction});
    bat_mv <= 16'hffff;
    repeat (600) @(posedge mclk);
    rdreg(`BBL_IDX_STAT);
    chk("hold", {9'h0, 3'h2, 1'b0, 19'h0_2710}, rd);
    wr(`BBL_IDX_CTRL, 32'h0000_0002);
    rdreg(`BBL_IDX_STAT);
    chk("release", {9'h0, 3'h6, 1'b0, 19'h0_2710}, rd);
    // every attack step code, every attack interval code
    for (int i = 0; i < 16; i++)
    begin
      do_reset();
      rt = (i < 8) ? i[2:0] : {1'b0, i[1:0]};
      wr(`BBL_IDX_L1_HOLD, 32'h0000_0010);
      wr(`BBL_IDX_L0_DWELL, {27'h0, i[3:0], 1'b0});
      wr(`BBL_IDX_L0_ATK, {24'h0, rt, 5'h00});
      wr(`BBL_IDX_L0_RLS, 32'h0000_001f);
      wr(`BBL_IDX_L0_THR, 32'h0000_0010);
      @(posedge mclk);
      bat_mv <= 16'h0bb8;
      hv_mv <= 16'($urandom);
      wait_change(n);
      chk("first step", {13'h0, step_amt(i[3:0])}, {13'h0, gain_reduction});
      wait_change(gap);
      chk("interval", rate_cyc(rt), gap);
      chk("second step", {13'h0, 19'(2 * step_amt(i[3:0]))}, {13'h0, gain_reduction});
      bat_mv <= 16'hffff;
    end
    summarize();
  end
endmodule : bbl_limiter_tb
`default_nettype wire
